/* logic/swd_pkg.sv */
// Functional notes
// - in receive mode compare stored word continuously
// - detect output rises on next bit clock
// - frame mode holds output packet-length bytes
// - two-bit field selects detect output behaviour
// - word length 12/16/20/24, compare only those
// - accept match with at most tolerance mismatches
// - bit clock comes from 32x recovery loop
// - latch writes select destination by low nibble
`default_nettype none
package swd_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_LATCH  = 8'h00;
   localparam logic [7:0] ADDR_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK   = 8'h0c;
   // latch select values in the low nibble of a latch write
   localparam logic [3:0] LAT_SYNC    = 4'hb;
   localparam logic [3:0] LAT_PKT     = 4'hc;
   // detect output modes
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_PULSE  = 2'h1;
   localparam logic [1:0] MODE_FRAME  = 2'h2;
   localparam logic [1:0] MODE_HOLD   = 2'h3;
   // compare masks per length code
   localparam logic [23:0] MASK_12    = 24'h000fff;
   localparam logic [23:0] MASK_16    = 24'h00ffff;
   localparam logic [23:0] MASK_20    = 24'h0fffff;
   localparam logic [23:0] MASK_24    = 24'hffffff;
   // status bit positions and axi responses
   localparam int          STS_MATCH  = 0;
   localparam int          STS_FRAME  = 1;
   localparam int          STS_LIVE   = 8;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   typedef enum logic [1:0] {S_IDLE = 2'b01, S_HIGH = 2'b10} swd_fsm_e;

   typedef struct packed {
      logic [23:0] word;
      logic [1:0]  len;
      logic [1:0]  tol;
      logic [1:0]  mode;
      logic [7:0]  pkt;
   } swd_cfg_s;

   typedef struct packed {
      logic        aw_ok;
      logic        w_ok;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      swd_cfg_s    cfg;
      logic        rx_en;
      logic [1:0]  sts;
      logic [1:0]  msk;
      logic [2:0]  clk_sync;
      logic [1:0]  dat_sync;
      logic [23:0] shift;
      logic        pend;
      swd_fsm_e    fsm;
      logic [10:0] cnt;
      logic        swd;
   } swd_state_s;

   localparam swd_state_s STATE_RST = '{fsm: S_IDLE, default: '0};
endpackage
`default_nettype wire

/* logic/swd_detector.sv */
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module swd_detector (
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // axi4-lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // recovered bit stream pins
   input  wire logic        rx_clk_pin,
   input  wire logic        rx_data_pin,
   // detect output and interrupt
   output logic             swd_out,
   output logic             irq
);
   swd_pkg::swd_state_s r;
   swd_pkg::swd_state_s n;
   logic        tick;
   logic        do_wr;
   logic [1:0]  sts_set;
   logic [1:0]  sts_clr;
   logic [23:0] shift_new;
   logic [23:0] cmp_mask;
   logic [4:0]  ones;
   logic        hit;

   ////////////////////////////////////////////////////////////////////////////
   // handshake and data outputs
   assign awready = !r.aw_ok && !r.bvalid;
   assign wready  = !r.w_ok && !r.bvalid;
   assign arready = !r.rvalid;
   assign bvalid  = r.bvalid;
   assign bresp   = r.bresp;
   assign rvalid  = r.rvalid;
   assign rdata   = r.rdata;
   assign rresp   = r.rresp;
   assign swd_out = r.swd;
   assign irq     = |(r.sts & r.msk);

   ////////////////////////////////////////////////////////////////////////////
   // bit clock edge, one tick per recovered bit from the 32x loop
   assign tick      = r.clk_sync[1] && !r.clk_sync[2] && r.rx_en;
   assign do_wr     = r.aw_ok && r.w_ok && !r.bvalid;
   // new bit enters at lsb, so the msb sent first ends up on top
   assign shift_new = {r.shift[22:0], r.dat_sync[1]};

   // compare mask from the length code
   always_comb begin
      unique case (r.cfg.len)
         2'd0: cmp_mask = swd_pkg::MASK_12;
         2'd1: cmp_mask = swd_pkg::MASK_16;
         2'd2: cmp_mask = swd_pkg::MASK_20;
         2'd3: cmp_mask = swd_pkg::MASK_24;
      endcase
   end

   // count mismatched bits inside the active length
   always_comb begin
      ones = 5'h00;
      for (int i = 0; i < 24; i++) begin
         ones = ones + {4'h0, (shift_new[i] ^ r.cfg.word[i]) & cmp_mask[i]};
      end
      hit = (ones <= {3'h0, r.cfg.tol});
   end

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      n       = r;
      sts_set = 2'h0;
      sts_clr = 2'h0;
      n.clk_sync = {r.clk_sync[1:0], rx_clk_pin};
      n.dat_sync = {r.dat_sync[0], rx_data_pin};
      // write address and data captured in either order
      if (awvalid && awready) begin
         n.aw_ok   = 1'b1;
         n.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         n.w_ok   = 1'b1;
         n.w_data = wdata;
         n.w_strb = wstrb;
      end
      if (r.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      // write effects once both halves are held
      if (do_wr) begin
         n.aw_ok  = 1'b0;
         n.w_ok   = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = swd_pkg::RESP_OKAY;
         unique case (r.aw_addr)
            swd_pkg::ADDR_LATCH: begin
               if (r.w_strb != 4'hf) begin
                  n.bresp = swd_pkg::RESP_SLV;
               end else if (r.w_data[3:0] == swd_pkg::LAT_SYNC) begin
                  n.cfg.word = r.w_data[31:8];
                  n.cfg.tol  = r.w_data[7:6];
                  n.cfg.len  = r.w_data[5:4];
               end else if (r.w_data[3:0] == swd_pkg::LAT_PKT) begin
                  n.cfg.pkt  = r.w_data[15:8];
                  n.cfg.mode = r.w_data[7:6];
               end
            end
            swd_pkg::ADDR_CTRL: begin
               if (r.w_strb[0]) begin
                  n.rx_en = r.w_data[0];
               end
            end
            swd_pkg::ADDR_STATUS: sts_clr = r.w_data[1:0] & {2{r.w_strb[0]}};
            swd_pkg::ADDR_MASK: begin
               if (r.w_strb[0]) begin
                  n.msk = r.w_data[1:0];
               end
            end
            default: n.bresp = swd_pkg::RESP_SLV;
         endcase
      end
      // read path, answer one cycle after the address
      if (r.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         n.rvalid = 1'b1;
         n.rresp  = swd_pkg::RESP_OKAY;
         unique case (araddr)
            swd_pkg::ADDR_LATCH:  n.rdata = {r.cfg.word, r.cfg.tol, r.cfg.len, swd_pkg::LAT_SYNC};
            swd_pkg::ADDR_CTRL:   n.rdata = {31'h0, r.rx_en};
            swd_pkg::ADDR_STATUS: n.rdata = {23'h0, r.swd, 6'h00, r.sts};
            swd_pkg::ADDR_MASK:   n.rdata = {30'h0, r.msk};
            default: begin
               n.rdata = 32'h0;
               n.rresp = swd_pkg::RESP_SLV;
            end
         endcase
      end
      // sliding compare on every received bit
      if (tick) begin
         n.shift = shift_new;
         n.pend  = hit;
      end
      // detect output sequencing
      if (!r.rx_en || r.cfg.mode == swd_pkg::MODE_OFF) begin
         n.fsm  = swd_pkg::S_IDLE;
         n.swd  = 1'b0;
         n.pend = 1'b0;
      end else if (tick) begin
         if (r.pend && (r.fsm == swd_pkg::S_IDLE || r.cfg.mode == swd_pkg::MODE_PULSE)) begin
            n.fsm = swd_pkg::S_HIGH;
            n.swd = 1'b1;
            n.cnt = {r.cfg.pkt, 3'h0};
            sts_set[swd_pkg::STS_MATCH] = 1'b1;
         end else begin
            unique case (r.fsm)
               swd_pkg::S_IDLE: n.swd = 1'b0;
               swd_pkg::S_HIGH: begin
                  if (r.cfg.mode == swd_pkg::MODE_PULSE) begin
                     n.fsm = swd_pkg::S_IDLE;
                     n.swd = 1'b0;
                  end else if (r.cfg.mode == swd_pkg::MODE_FRAME) begin
                     if (r.cnt <= 11'h001) begin
                        n.fsm = swd_pkg::S_IDLE;
                        n.swd = 1'b0;
                        sts_set[swd_pkg::STS_FRAME] = 1'b1;
                     end else begin
                        n.cnt = r.cnt - 11'h001;
                     end
                  end
               end
            endcase
         end
      end
      // sticky status, a set beats a clear in the same cycle
      n.sts = (r.sts & ~sts_clr) | sts_set;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= swd_pkg::STATE_RST;
      end else if (ce) begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   AST_SWD_NEXT_BIT: assert property (tick && r.pend && r.fsm == swd_pkg::S_IDLE && r.cfg.mode != swd_pkg::MODE_OFF
      |=> swd_out && r.sts[swd_pkg::STS_MATCH])
      else $error("detect output did not rise on the bit after a match");
   // mode off clears the pending match, so only a live mode must keep it
   AST_TOL_MATCH: assert property (tick && r.cfg.mode != swd_pkg::MODE_OFF && ones <= {3'h0, r.cfg.tol}
      |=> r.pend)
      else $error("match within tolerance not flagged");
   AST_TOL_REJECT: assert property (tick && ones > {3'h0, r.cfg.tol} |=> !r.pend)
      else $error("match flagged beyond tolerance");
   AST_MASK_LEN: assert property ($countones(cmp_mask) == 12 + 4 * r.cfg.len)
      else $error("compare width does not follow length code");
   AST_FRAME_LOAD: assert property ($rose(swd_out) && r.cfg.mode == swd_pkg::MODE_FRAME
      |-> r.cnt == {r.cfg.pkt, 3'h0})
      else $error("frame count not loaded with packet bits");
   AST_PULSE_DROP: assert property (swd_out && tick && !r.pend && r.cfg.mode == swd_pkg::MODE_PULSE
      |=> !swd_out)
      else $error("pulse mode held the output");
   AST_OFF_LOW: assert property (r.cfg.mode == swd_pkg::MODE_OFF |=> !swd_out)
      else $error("detect output high while off");
   AST_LATCH_SYNC: assert property (do_wr && r.aw_addr == swd_pkg::ADDR_LATCH && r.w_strb == 4'hf
      && r.w_data[3:0] == swd_pkg::LAT_SYNC |=> r.cfg.word == $past(r.w_data[31:8]))
      else $error("sync latch write not stored");
   AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");

   COV_MATCH: cover property ($rose(swd_out));
   COV_FRAME_END: cover property ($rose(r.sts[swd_pkg::STS_FRAME]));
   COV_IRQ: cover property ($rose(irq));
endmodule
`default_nettype wire

/* test/swd_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module swd_tx_model (
   // bench clock
   input  wire logic aclk,
   // recovered bit stream
   output logic      rx_clk_pin,
   output logic      rx_data_pin
);
   // idle: bit clock low, data low
   initial begin
      rx_clk_pin  = 1'b0;
      rx_data_pin = 1'b0;
   end
   // send n bits, 4 low and 6 high aclk per bit, clock stands low after
   task automatic send(input logic [23:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         rx_clk_pin  <= 1'b0;
         rx_data_pin <= w[i];
         repeat (4) @(posedge aclk);
         rx_clk_pin <= 1'b1;
         repeat (6) @(posedge aclk);
      end
      rx_clk_pin  <= 1'b0;
      rx_data_pin <= ~rx_data_pin; // released line shows inverse
   endtask
endmodule
`default_nettype wire

/* test/swd_detector_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module swd_detector_bench;
   logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, rx_clk, rx_dat, swd, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   int          num_errors, comparisons, cycles;

   swd_detector swd_detector_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .rx_clk_pin(rx_clk), .rx_data_pin(rx_dat),
      .swd_out(swd), .irq(irq));
   swd_tx_model swd_tx_model_inst (.aclk(aclk), .rx_clk_pin(rx_clk), .rx_data_pin(rx_dat));

   // 250 mhz clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         num_errors++;
         test_done();
      end
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write, both halves offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic ha, hw;
      ha = 1'b1;
      hw = 1'b1;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (ha || hw) begin
         @(posedge aclk);
         if (ha && awready) begin
            ha = 1'b0;
            awvalid <= 1'b0;
         end
         if (hw && wready) begin
            hw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk(bresp, er);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   // axi4-lite read
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      chk(rdata, ed);
      chk(rresp, er);
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // program sync latch and packet latch
   task automatic cfg(input logic [23:0] w, input logic [1:0] tol, input logic [1:0] len,
                      input logic [1:0] md, input logic [7:0] pk);
      wr(8'h00, {w, tol, len, 4'hb}, 4'hf, 2'h0);
      wr(8'h00, {16'h0000, pk, md, 2'h0, 4'hc}, 4'hf, 2'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(8'h00, 32'h0000000b, 2'h0);
      rd(8'h04, 32'h00000000, 2'h0);
      rd(8'h08, 32'h00000000, 2'h0);
      rd(8'h10, 32'h00000000, 2'h2);
      wr(8'h10, 32'h00000001, 4'hf, 2'h2);
      wr(8'h00, 32'habcdef7b, 4'h1, 2'h2);
      rd(8'h00, 32'h0000000b, 2'h0);
      $display("t_regs done");
   endtask
   // each length code with its tolerance, at and past the limit
   task automatic t_tol();
      logic [23:0] w, f, x;
      w = 24'h5a3c96;
      for (int c = 0; c < 4; c++) begin
         f = (24'h000001 << (c + 1)) - 24'h000001;
         // x flips bit 23, which lies above the sent length, so send never drives it onto the line
         x = (c < 3) ? 24'h800000 : 24'h000000;
         cfg(w, c[1:0], c[1:0], 2'h1, 8'h00);
         swd_tx_model_inst.send(w ^ f ^ x, 12 + 4 * c);
         swd_tx_model_inst.send(24'h000000, 1);
         chk(swd, 1'b0);
         swd_tx_model_inst.send(w ^ (f >> 1) ^ x, 12 + 4 * c);
         swd_tx_model_inst.send(24'h000000, 1);
         chk(swd, 1'b1);
      end
      $display("t_tol done");
   endtask
   // pulse with interrupt, then clear
   task automatic t_pulse();
      cfg(24'h000abc, 2'h0, 2'h0, 2'h1, 8'h00);
      wr(8'h0c, 32'h00000001, 4'hf, 2'h0);
      wr(8'h08, 32'h00000003, 4'hf, 2'h0);
      swd_tx_model_inst.send(24'h000abc, 12);
      swd_tx_model_inst.send(24'h000000, 1);
      chk({swd, irq}, 2'h3);
      swd_tx_model_inst.send(24'h000000, 1);
      chk(swd, 1'b0);
      rd(8'h08, 32'h00000001, 2'h0);
      wr(8'h08, 32'h00000001, 4'hf, 2'h0);
      chk(irq, 1'b0);
      // clock enable low freezes the receiver, so a matching word is lost
      ce <= 1'b0;
      swd_tx_model_inst.send(24'h000abc, 12);
      swd_tx_model_inst.send(24'h000000, 1);
      ce <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(swd, 1'b0);
      $display("t_pulse done");
   endtask
   // frame of one byte, hold, off
   task automatic t_frame();
      cfg(24'h000abc, 2'h0, 2'h0, 2'h2, 8'h01);
      swd_tx_model_inst.send(24'h001578, 13);
      chk(swd, 1'b1);
      swd_tx_model_inst.send(24'h000000, 7);
      chk(swd, 1'b1);
      swd_tx_model_inst.send(24'h000000, 1);
      chk(swd, 1'b0);
      rd(8'h08, 32'h00000003, 2'h0);
      cfg(24'h000abc, 2'h0, 2'h0, 2'h3, 8'h00);
      swd_tx_model_inst.send(24'h001578, 23);
      chk(swd, 1'b1);
      wr(8'h04, 32'h00000000, 4'hf, 2'h0);
      chk(swd, 1'b0);
      wr(8'h04, 32'h00000001, 4'hf, 2'h0);
      cfg(24'h000abc, 2'h0, 2'h0, 2'h0, 8'h00);
      swd_tx_model_inst.send(24'h001578, 13);
      chk(swd, 1'b0);
      $display("t_frame done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // reset, then the scenarios
   initial begin
      num_errors  = 0;
      comparisons = 0;
      cycles      = 0;
      aresetn     = 1'b0;
      ce          = 1'b1;
      awvalid     = 1'b0;
      wvalid      = 1'b0;
      bready      = 1'b0;
      arvalid     = 1'b0;
      rready      = 1'b0;
      awaddr      = 8'h00;
      araddr      = 8'h00;
      wdata       = 32'h0;
      wstrb       = 4'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      wr(8'h04, 32'h00000001, 4'hf, 2'h0);
      t_pulse();
      t_tol();
      t_frame();
      test_done();
   end
endmodule
`default_nettype wire
